// ---- trs_timing_reference_selector.sv ----
// Timing reference selection, failover and timing output control
`timescale 1ns/10ps
module trs_timing_reference_selector #(
  parameter logic [trs_pkg::CNT_W-1:0] REVERT_CYCLES =
    trs_pkg::REVERT_CYCLES_DEF
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic                                linkClk,
  input  wire trs_pkg::trsNodeCfg_type             nodeCfg,
  input  wire trs_pkg::trsBitsCfg_type [1:0]       bitsCfg,
  input  wire logic [1:0]                          bitsLosPin,
  input  wire logic [1:0][3:0]                     bitsSsm,
  input  wire logic [3:0]                          lineWorking,
  input  wire logic [3:0][3:0]                     lineSsm,
  output logic [2:0]                               selSource,
  output logic [3:0]                               selRank,
  output logic [1:0]                               activeRef,
  output logic                                     refSwitch,
  output logic [1:0][2:0]                          outSource,
  output logic [1:0]                               bitsOutAis,
  output logic [1:0]                               bitsOutActive,
  output logic [1:0]                               bitsOutB8zs
);
  import trs_pkg::*;

  // Selector overview, in short:
  // Three priority slots, slot 0 first; each names one source code.
  // Source codes: oscillator, two timing inputs, four line ports, none.
  // A slot is usable when the mode allows its source, the source is
  // healthy and its rank is not the do-not-use rank.
  // Any change of the node settings re-selects at once, with no hold.
  // Failover to the lowest usable slot lands on the next edge.
  // Reversion to a better slot waits out REVERT_CYCLES good cycles;
  // any break in that run starts the count again.
  // Reversion only looks at slots above the active one; a worse slot
  // that recovers only takes over while the active slot is unusable.
  // With no usable slot the oscillator drives, but the slot is kept,
  // so a slot that recovers is picked up by the normal checks.
  // Hazard: a slot naming the same source twice is harmless; the
  // lower slot simply wins.
  // Ranks grow with quality; the reserved code takes a set rank, which
  // may sit on an odd value between two standard levels.
  // The first-generation setting folds both newer codes down to stratum 3.
  // A timing input without messaging ranks as unknown, not failed,
  // so it stays usable while its pin shows signal.
  // The oscillator always counts as healthy, at the stratum 3 rank.
  // Loss pins are asynchronous and pass three flip-flops; a level is
  // taken once the last two agree, four edges after the pin moves.
  // Line status and received codes come from logic on this clock and
  // are used as they stand.
  // Each timing output has its own list of three line ports, scanned
  // last to first, so the first working entry wins; out of service forces every control low.
  // Alarm only when messaging cannot carry quality (messaging off or
  // superframe framing) and the chosen port ranks at or below the
  // limit, or no listed port works at all.
  // Controls cross to the link clock through three stages and are
  // taken whole once two stages agree, so a word never tears.
  // Limitation: a control change shorter than two link periods may be
  // missed; settings are levels, so this costs nothing here.
  // The link side has no reset of its own: the core reset crosses and
  // clears the controls, so hold it for at least four link periods.
  // Trade-off: choice and rank are registered, one edge late, to keep
  // the long compare chains away from the output pins.

  // Core domain state
  typedef struct packed {
    // Loss pin synchroniser stages and the accepted level
    logic [NUM_BITS-1:0]                 los1;
    logic [NUM_BITS-1:0]                 los2;
    logic [NUM_BITS-1:0]                 los3;
    logic [NUM_BITS-1:0]                 losSeen;
    // Slot choice and the reversion run count
    logic [1:0]                          activeIdx;
    logic [CNT_W-1:0]                    holdCnt;
    // Settings seen last edge, to spot any change
    trsNodeCfg_type                      cfgSeen;
    // Registered outputs
    logic [SRC_W-1:0]                    selSrc;
    logic [RANK_W-1:0]                   selRank;
    logic                                switchEv;
    logic [NUM_BITS-1:0][SRC_W-1:0]      outSrc;
    // Controls handed to the link side
    trsLinkCtl_type [NUM_BITS-1:0]       linkCtl;
  } trsCore_type;

  // Link domain state, including its crossing stages
  typedef struct packed {
    // Reset crossing stages and the accepted level
    logic                                rst1;
    logic                                rst2;
    logic                                rst3;
    logic                                rstSeen;
    // Control crossing stages and the accepted word
    trsLinkCtl_type [NUM_BITS-1:0]       c1;
    trsLinkCtl_type [NUM_BITS-1:0]       c2;
    trsLinkCtl_type [NUM_BITS-1:0]       c3;
    trsLinkCtl_type [NUM_BITS-1:0]       outCtl;
  } trsLink_type;

  trsCore_type core_r;
  trsCore_type core_nxt;
  trsLink_type link_r;
  trsLink_type link_nxt;

  // Is a source code a line port
  function automatic logic isLine(input logic [SRC_W-1:0] src);
    return (src >= SRC_LINE0) && (src <= SRC_LINEN);
  endfunction

  // Line port index of a line source code
  function automatic logic [1:0] lineIdx(input logic [SRC_W-1:0] src);
    logic [SRC_W-1:0] d;
    // Only meaningful once isLine has said yes
    d = src - SRC_LINE0;
    return d[1:0];
  endfunction

  // Status messaging only runs with extended superframe framing
  function automatic logic ssmOn(input trsBitsCfg_type c);
    return c.syncMsgEn && c.esf;
  endfunction

  // Mode decides which sources may fill a priority slot
  function automatic logic allowed(
    input trsMode_type      mode,
    input logic [SRC_W-1:0] src
  );
    logic ok;
    ok = 1'b0;
    case (mode)
      MODE_EXT:   ok = (src <= SRC_BITS2);
      MODE_LINE:  ok = (src == SRC_INT) || isLine(src);
      MODE_MIXED: ok = (src <= SRC_LINEN);
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Health of a source; the oscillator never fails
  function automatic logic healthy(
    input logic [SRC_W-1:0]    src,
    input logic [NUM_BITS-1:0] los,
    input trsBitsCfg_type [1:0] bc,
    input logic [3:0]          work
  );
    logic ok;
    ok = 1'b0;
    if (src == SRC_INT) begin
      ok = 1'b1;
    end else if (src == SRC_BITS1) begin
      ok = bc[0].facilityInService && !los[0];
    end else if (src == SRC_BITS2) begin
      ok = bc[1].facilityInService && !los[1];
    end else if (isLine(src)) begin
      ok = work[lineIdx(src)];
    end
    return ok;
  endfunction

  // Quality rank of a source as seen now
  function automatic logic [RANK_W-1:0] rankOf(
    input logic [SRC_W-1:0]     src,
    input trsNodeCfg_type       nc,
    input trsBitsCfg_type [1:0] bc,
    input logic [1:0][3:0]      bs,
    input logic [3:0][3:0]      ls
  );
    logic [RANK_W-1:0] r;
    r = RANK_DUS;
    if (src == SRC_INT) begin
      r = RANK_ST3;
    end else if (src == SRC_BITS1 || src == SRC_BITS2) begin
      // Without messaging the quality is unknown, not failed
      if (ssmOn(bc[src[1]]))
        r = trsRankOf(bs[src[1]], nc.gen2Set, nc.reservedQualityLevel);
      else
        r = RANK_STU;
    end else if (isLine(src)) begin
      r = trsRankOf(ls[lineIdx(src)], nc.gen2Set,
                    nc.reservedQualityLevel);
    end
    return r;
  endfunction

  // Core next-state logic
  always_comb begin
    logic [NUM_REF-1:0] usable;
    logic               found;
    logic [1:0]         first;
    logic               oFound;
    logic [SRC_W-1:0]   oSrc;
    logic [RANK_W-1:0]  oRank;
    logic [SRC_W-1:0]   cand;
    usable = '0;
    found  = 1'b0;
    first  = 2'h0;
    oFound = 1'b0;
    oSrc   = SRC_NONE;
    oRank  = RANK_DUS;
    cand   = SRC_INT;
    core_nxt = core_r;

    // Loss pins pass three stages; a change counts once two agree
    core_nxt.los1 = bitsLosPin;
    core_nxt.los2 = core_r.los1;
    core_nxt.los3 = core_r.los2;
    for (int k = 0; k < NUM_BITS; k++) begin
      if (core_r.los2[k] == core_r.los3[k])
        core_nxt.losSeen[k] = core_r.los3[k];
    end

    // Usable slots, and the best one in priority order
    for (int i = 0; i < NUM_REF; i++) begin
      cand = nodeCfg.refSrc[i];
      usable[i] = allowed(nodeCfg.mode, cand)
        && healthy(cand, core_r.losSeen, bitsCfg, lineWorking)
        && (rankOf(cand, nodeCfg, bitsCfg, bitsSsm, lineSsm)
            != RANK_DUS);
    end
    // Lowest usable slot wins; scan downwards so it lands last
    for (int i = NUM_REF - 1; i >= 0; i--) begin
      if (usable[i]) begin
        found = 1'b1;
        first = 2'(i);
      end
    end

    // Slot choice: config change, failover, then reversion
    core_nxt.cfgSeen = nodeCfg;
    if (nodeCfg != core_r.cfgSeen) begin
      core_nxt.activeIdx = first;
      core_nxt.holdCnt   = '0;
    end else if (!usable[core_r.activeIdx]) begin
      if (found)
        core_nxt.activeIdx = first;
      core_nxt.holdCnt = '0;
    end else if (nodeCfg.revertEn && found
                 && (first < core_r.activeIdx)) begin
      // Lower slot must stay good for the whole delay
      if (core_r.holdCnt >= REVERT_CYCLES - 1'b1) begin
        core_nxt.activeIdx = first;
        core_nxt.holdCnt   = '0;
      end else begin
        core_nxt.holdCnt = core_r.holdCnt + 1'b1;
      end
    end else begin
      core_nxt.holdCnt = '0;
    end

    // Nothing usable leaves the oscillator in charge
    if (usable[core_nxt.activeIdx])
      core_nxt.selSrc = nodeCfg.refSrc[core_nxt.activeIdx];
    else
      core_nxt.selSrc = SRC_INT;
    // Rank follows the source actually driving
    core_nxt.selRank =
      rankOf(core_nxt.selSrc, nodeCfg, bitsCfg, bitsSsm, lineSsm);
    // One-edge pulse whenever the driving source moves
    core_nxt.switchEv = (core_nxt.selSrc != core_r.selSrc);

    // Timing outputs pick from their own list of working ports
    for (int k = 0; k < NUM_BITS; k++) begin
      oFound = 1'b0;
      oSrc   = SRC_NONE;
      oRank  = RANK_DUS;
      for (int j = NUM_OUT_REF - 1; j >= 0; j--) begin
        cand = bitsCfg[k].outRef[j];
        if (isLine(cand) && lineWorking[lineIdx(cand)]) begin
          oFound = 1'b1;
          oSrc   = cand;
          oRank  = rankOf(cand, nodeCfg, bitsCfg, bitsSsm, lineSsm);
        end
      end
      // Out of service parks the source at none
      core_nxt.outSrc[k] =
        bitsCfg[k].facilityInService ? oSrc : SRC_NONE;
      // Gated before the crossing, so the link side only copies
      core_nxt.linkCtl[k].active =
        bitsCfg[k].facilityInService;
      core_nxt.linkCtl[k].b8zs = bitsCfg[k].facilityInService
        && bitsCfg[k].b8zs;
      // Alarm when quality cannot be signalled and falls too low
      core_nxt.linkCtl[k].ais = bitsCfg[k].facilityInService
        && !ssmOn(bitsCfg[k])
        && (!oFound
            || oRank <= bitsCfg[k].alarmSignalQualityLimit);
    end
  end

  // Core register
  always_ff @(posedge ref_clk) begin
    if (rst)
      core_r <= '0;
    else
      core_r <= core_nxt;
  end

  // Link next-state logic; reset itself crosses in three stages
  always_comb begin
    link_nxt = link_r;
    link_nxt.rst1 = rst;
    link_nxt.rst2 = link_r.rst1;
    link_nxt.rst3 = link_r.rst2;
    if (link_r.rst2 == link_r.rst3)
      link_nxt.rstSeen = link_r.rst3;
    // Control word enters the three stages
    link_nxt.c1 = core_r.linkCtl;
    link_nxt.c2 = link_r.c1;
    link_nxt.c3 = link_r.c2;
    // Each control level is taken only when two stages agree
    for (int k = 0; k < NUM_BITS; k++) begin
      if (link_r.rstSeen) begin
        link_nxt.outCtl[k] = '0;
      end else if (link_r.c2[k] == link_r.c3[k]) begin
        link_nxt.outCtl[k] = link_r.c3[k];
      end
    end
  end

  // Link register; stages run free so reset can propagate
  always_ff @(posedge linkClk) begin
    link_r <= link_nxt;
  end

  // Core outputs straight from the core register
  always_comb begin
    selSource = core_r.selSrc;
    selRank   = core_r.selRank;
    activeRef = core_r.activeIdx;
    refSwitch = core_r.switchEv;
    outSource = core_r.outSrc;
  end

  // Timing output controls straight from the link register; service
  // gating is done before the crossing, so no gate can glitch here
  for (genvar k = 0; k < NUM_BITS; k++) begin : g_out
    assign bitsOutAis[k]    = link_r.outCtl[k].ais;
    assign bitsOutActive[k] = link_r.outCtl[k].active;
    assign bitsOutB8zs[k]   = link_r.outCtl[k].b8zs;
  end

endmodule

// ---- trs_pkg.sv ----
// Constants, carriers and quality mapping for the timing reference selector
package trs_pkg;

  localparam int NUM_LINE    = 4;
  localparam int NUM_REF     = 3;
  localparam int NUM_BITS    = 2;
  localparam int NUM_OUT_REF = 3;
  localparam int SRC_W       = 3;
  localparam int RANK_W      = 4;
  localparam int CNT_W       = 36;

  // Reference source codes
  localparam logic [SRC_W-1:0] SRC_INT   = 3'h0;
  localparam logic [SRC_W-1:0] SRC_BITS1 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_BITS2 = 3'h2;
  localparam logic [SRC_W-1:0] SRC_LINE0 = 3'h3;
  localparam logic [SRC_W-1:0] SRC_LINEN = 3'h6;
  localparam logic [SRC_W-1:0] SRC_NONE  = 3'h7;

  // Received sync status codes
  localparam logic [3:0] SSM_STU  = 4'h0;
  localparam logic [3:0] SSM_PRS  = 4'h1;
  localparam logic [3:0] SSM_TNC  = 4'h4;
  localparam logic [3:0] SSM_ST2  = 4'h7;
  localparam logic [3:0] SSM_ST3  = 4'ha;
  localparam logic [3:0] SSM_SMC  = 4'hc;
  localparam logic [3:0] SSM_ST3E = 4'hd;
  localparam logic [3:0] SSM_RES  = 4'he;

  // Quality ranks, higher is better; odd ranks are free for the reserved code
  localparam logic [RANK_W-1:0] RANK_DUS  = 4'h0;
  localparam logic [RANK_W-1:0] RANK_SMC  = 4'h2;
  localparam logic [RANK_W-1:0] RANK_ST3  = 4'h4;
  localparam logic [RANK_W-1:0] RANK_ST3E = 4'h6;
  localparam logic [RANK_W-1:0] RANK_TNC  = 4'h8;
  localparam logic [RANK_W-1:0] RANK_ST2  = 4'ha;
  localparam logic [RANK_W-1:0] RANK_STU  = 4'hc;
  localparam logic [RANK_W-1:0] RANK_PRS  = 4'he;

  // Reversion delay
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint REVERT_TIME_S = 300;
  localparam logic [CNT_W-1:0] REVERT_CYCLES_DEF =
    CNT_W'(REVERT_TIME_S * CLK_HZ);

  typedef enum logic [1:0] {
    MODE_EXT   = 2'b00,
    MODE_LINE  = 2'b01,
    MODE_MIXED = 2'b10
  } trsMode_type;

  typedef struct packed {
    trsMode_type                         mode;
    logic [NUM_REF-1:0][SRC_W-1:0]       refSrc;
    logic                                revertEn;
    logic                                gen2Set;
    logic [RANK_W-1:0]                   reservedQualityLevel;
  } trsNodeCfg_type;

  typedef struct packed {
    logic                                facilityInService;
    logic                                b8zs;
    logic                                esf;
    logic                                syncMsgEn;
    logic [RANK_W-1:0]                   alarmSignalQualityLimit;
    logic [NUM_OUT_REF-1:0][SRC_W-1:0]   outRef;
  } trsBitsCfg_type;

  typedef struct packed {
    logic ais;
    logic active;
    logic b8zs;
  } trsLinkCtl_type;

  // Code to rank; first-generation set folds newer codes down
  function automatic logic [RANK_W-1:0] trsRankOf(
    input logic [3:0]        code,
    input logic              gen2,
    input logic [RANK_W-1:0] resRank
  );
    logic [RANK_W-1:0] r;
    r = RANK_DUS;
    case (code)
      SSM_PRS:  r = RANK_PRS;
      SSM_STU:  r = RANK_STU;
      SSM_ST2:  r = RANK_ST2;
      SSM_TNC:  r = gen2 ? RANK_TNC : RANK_ST3;
      SSM_ST3E: r = gen2 ? RANK_ST3E : RANK_ST3;
      SSM_ST3:  r = RANK_ST3;
      SSM_SMC:  r = RANK_SMC;
      SSM_RES:  r = resRank;
      default:  r = RANK_DUS;
    endcase
    return r;
  endfunction

endpackage

// ---- trs_sel_checker.sv ----
// Port assertions for the timing reference selector
`timescale 1ns/10ps
module trs_sel_checker #(
  parameter logic [trs_pkg::CNT_W-1:0] REVERT_CYCLES = 1
) (
  input wire logic                      ref_clk,
  input wire logic                      rst,
  input wire logic                      linkClk,
  input wire trs_pkg::trsNodeCfg_type   nodeCfg,
  input wire trs_pkg::trsBitsCfg_type [1:0] bitsCfg,
  input wire logic [3:0]                lineWorking,
  input wire logic [3:0][3:0]           lineSsm,
  input wire logic [2:0]                selSource,
  input wire logic [3:0]                selRank,
  input wire logic                      refSwitch,
  input wire logic [1:0][2:0]           outSource,
  input wire logic [1:0]                bitsOutAis,
  input wire logic [1:0]                bitsOutActive,
  input wire logic [1:0]                bitsOutB8zs
);
  import trs_pkg::*;
  logic [3:0] lineWorking_r;

  // Port status one edge back, matching the selection latency
  always_ff @(posedge ref_clk) begin
    lineWorking_r <= lineWorking;
  end

  a_switch_pulse: assert property (@(posedge ref_clk)
    disable iff (rst) refSwitch == (selSource != $past(selSource)))
    else $error("switch pulse out of step with source change");
  a_ext_sources: assert property (@(posedge ref_clk)
    disable iff (rst) $past(nodeCfg.mode) == MODE_EXT |->
    selSource <= SRC_BITS2) else $error("line port used in external mode");
  a_line_sources: assert property (@(posedge ref_clk)
    disable iff (rst) $past(nodeCfg.mode) == MODE_LINE &&
    selSource != SRC_INT |-> selSource >= SRC_LINE0 &&
    selSource <= SRC_LINEN && lineWorking_r[2'(selSource - SRC_LINE0)])
    else $error("line mode source not a working port");
  a_osc_rank: assert property (@(posedge ref_clk)
    disable iff (rst) !$past(rst) && selSource == SRC_INT |->
    selRank == RANK_ST3) else $error("oscillator rank wrong");
  a_gen1_fold: assert property (@(posedge ref_clk)
    disable iff (rst) !$past(rst) && !$past(nodeCfg.gen2Set) &&
    selSource == SRC_LINE0 && $past(lineSsm[0]) == SSM_ST3E |->
    selRank == RANK_ST3) else $error("newer code not folded down");
  a_out_ref: assert property (@(posedge ref_clk)
    disable iff (rst) !$past(rst) && outSource[0] != SRC_NONE |->
    outSource[0] >= SRC_LINE0 && outSource[0] <= SRC_LINEN &&
    lineWorking_r[2'(outSource[0] - SRC_LINE0)])
    else $error("output reference not a working port");
  a_out_idle: assert property (@(posedge linkClk)
    disable iff (rst) !bitsCfg[0].facilityInService [*8] |->
    !bitsOutActive[0] && !bitsOutAis[0])
    else $error("timing output live while out of service");
  a_coding_b8zs: assert property (@(posedge linkClk)
    disable iff (rst)
    (bitsCfg[0].facilityInService && bitsCfg[0].b8zs) [*8] |->
    bitsOutB8zs[0]) else $error("output coding does not follow setting");
  a_sf_alarm: assert property (@(posedge linkClk)
    disable iff (rst) (bitsCfg[1].facilityInService && !bitsCfg[1].esf &&
    bitsCfg[1].alarmSignalQualityLimit == 4'hf) [*8] |-> bitsOutAis[1])
    else $error("alarm signal missing at quality limit");
endmodule

bind trs_timing_reference_selector trs_sel_checker #(
  .REVERT_CYCLES(REVERT_CYCLES)) trs_sel_checker_inst (.ref_clk, .rst,
  .linkClk, .nodeCfg, .bitsCfg, .lineWorking, .lineSsm, .selSource,
  .selRank, .refSwitch, .outSource, .bitsOutAis, .bitsOutActive,
  .bitsOutB8zs);

// ---- trs_source_model.sv ----
// Far-side model: timing supply inputs and optical line ports
`timescale 1ns/10ps
module trs_source_model (
  input  wire logic            ref_clk,
  input  wire logic [1:0]      lossReq,
  input  wire logic [3:0]      portUp,
  input  wire logic [1:0][3:0] bitsCode,
  input  wire logic [3:0][3:0] portCode,
  output logic [1:0]           bitsLosPin,
  output logic [1:0][3:0]      bitsSsm,
  output logic [3:0]           lineWorking,
  output logic [3:0][3:0]      lineSsm
);
  initial {bitsLosPin, bitsSsm, lineWorking, lineSsm} = '0;

  // Loss of signal lands off the core clock grid on purpose
  always @(lossReq) begin
    bitsLosPin <= #3 lossReq;
  end

  // Port status and codes follow the bench one core edge later, by
  // non-blocking update, so the design never races the bench
  always @(posedge ref_clk) begin
    lineWorking <= portUp;
    lineSsm <= portCode;
    bitsSsm <= bitsCode;
  end
endmodule

// ---- timing_reference_selector_tb_top.sv ----
// Self-checking bench for the timing reference selector
`timescale 1ns/10ps
module timing_reference_selector_tb_top;
  import trs_pkg::*;
  trsNodeCfg_type       nodeCfg;
  trsBitsCfg_type [1:0] bitsCfg;
  trsBitsCfg_type       b;
  logic                 ref_clk = 1'b0;
  logic                 linkClk = 1'b0;
  logic                 rst = 1'b1;
  logic                 refSwitch;
  logic [1:0]           lossReq, bitsLosPin, activeRef;
  logic [1:0]           bitsOutAis, bitsOutActive, bitsOutB8zs;
  logic [3:0]           portUp, lineWorking, selRank;
  logic [1:0][3:0]      bitsCode, bitsSsm;
  logic [3:0][3:0]      portCode, lineSsm;
  logic [2:0]           selSource;
  logic [1:0][2:0]      outSource;
  logic [3:0]           codes [8];
  int                   n_errors, checks_done, seed;

  // Two unrelated clocks; rising edges never coincide
  always #5 ref_clk = ~ref_clk;
  always #24 linkClk = ~linkClk;

  trs_timing_reference_selector #(.REVERT_CYCLES(CNT_W'(20)))
    trs_timing_reference_selector_inst (.ref_clk, .rst, .linkClk,
    .nodeCfg, .bitsCfg, .bitsLosPin, .bitsSsm, .lineWorking, .lineSsm,
    .selSource, .selRank, .activeRef, .refSwitch, .outSource,
    .bitsOutAis, .bitsOutActive, .bitsOutB8zs);
  trs_source_model trs_source_model_inst (.ref_clk, .lossReq, .portUp,
    .bitsCode, .portCode, .bitsLosPin, .bitsSsm, .lineWorking, .lineSsm);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Selected source and slot together
  task automatic sel(input logic [2:0] s, input logic [1:0] a);
    chk(8'(selSource), 8'(s));
    chk(8'(activeRef), 8'(a));
  endtask

  // Rank expected for a received code, reserved code set to 5
  function automatic logic [3:0] expRank(logic [3:0] c, logic g);
    case (c)
      SSM_PRS: return RANK_PRS;
      SSM_STU: return RANK_STU;
      SSM_ST2: return RANK_ST2;
      SSM_TNC: return g ? RANK_TNC : RANK_ST3;
      SSM_ST3E: return g ? RANK_ST3E : RANK_ST3;
      SSM_ST3: return RANK_ST3;
      SSM_SMC: return RANK_SMC;
      SSM_RES: return 4'h5;
      default: return RANK_DUS;
    endcase
  endfunction

  // First working line port in an output's list
  function automatic logic [2:0] expOut(int i);
    logic [2:0] s;
    for (int k = 0; k < 3; k++) begin
      s = bitsCfg[i].outRef[k];
      if (s >= SRC_LINE0 && s <= SRC_LINEN && portUp[2'(s - SRC_LINE0)])
        return s;
    end
    return SRC_NONE;
  endfunction

  // Alarm expected from the first working port in an output's list
  function automatic logic expAis(int i);
    logic [2:0] s;
    s = expOut(i);
    if (s == SRC_NONE)
      return 1'b1;
    return expRank(portCode[2'(s - SRC_LINE0)], nodeCfg.gen2Set)
           <= bitsCfg[i].alarmSignalQualityLimit;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, well past the expected run of about 900 cycles
  initial begin
    #50000;
    n_errors++;
    complete_run();
  end

  initial begin
    seed = 32'hc2f0;
    n_errors = 0;
    checks_done = 0;
    lossReq = '0;
    portUp = 4'hf;
    bitsCode = '0;
    portCode = '0;
    codes = '{SSM_STU, SSM_PRS, SSM_TNC, SSM_ST2, SSM_ST3, SSM_SMC,
              SSM_ST3E, SSM_RES};
    nodeCfg = '{MODE_EXT, {SRC_INT, SRC_BITS2, SRC_BITS1}, 1'b0, 1'b0,
                4'h5};
    bitsCfg[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 9'h0};
    bitsCfg[1] = bitsCfg[0];
    cyc(10);
    rst = 1'b0;
    cyc(3);
    sel(SRC_BITS1, 2'd0);
    lossReq = 2'b01;
    cyc(10);
    sel(SRC_BITS2, 2'd1);
    lossReq = 2'b00;
    cyc(40);
    sel(SRC_BITS2, 2'd1);
    lossReq = 2'b10;
    cyc(10);
    sel(SRC_BITS1, 2'd0);
    lossReq = 2'b11;
    cyc(10);
    sel(SRC_INT, 2'd2);
    chk(8'(selRank), 8'(RANK_ST3));
    // Recovery of the primary must wait out the hold count
    nodeCfg.revertEn = 1'b1;
    lossReq = 2'b10;
    cyc(12);
    sel(SRC_INT, 2'd2);
    cyc(30);
    sel(SRC_BITS1, 2'd0);
    nodeCfg.refSrc = {SRC_INT, SRC_BITS1, SRC_LINE0};
    cyc(3);
    sel(SRC_BITS1, 2'd1);
    nodeCfg.mode = MODE_LINE;
    nodeCfg.refSrc = {SRC_BITS1, SRC_LINE0, 3'h4};
    cyc(3);
    sel(3'h4, 2'd0);
    portUp = 4'b1101;
    cyc(3);
    sel(SRC_LINE0, 2'd1);
    portUp = 4'b1100;
    cyc(3);
    chk(8'(selSource), 8'(SRC_INT));
    nodeCfg.mode = MODE_MIXED;
    cyc(3);
    sel(SRC_BITS1, 2'd2);
    // Every code under both message sets; ports up before the switch
    portUp = 4'hf;
    cyc(2);
    nodeCfg.mode = MODE_LINE;
    nodeCfg.refSrc = {SRC_INT, SRC_INT, SRC_LINE0};
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 8; i++) begin
        nodeCfg.gen2Set = g[0];
        portCode[0] = codes[i];
        cyc(3);
        chk(8'(selRank), 8'(expRank(codes[i], g[0])));
      end
    end
    // Timing outputs: two corner settings, then random ones
    for (int i = 0; i < 12; i++) begin
      bitsCfg = 34'({$random(seed), $random(seed)});
      portUp = 4'($random(seed));
      portCode = 16'($random(seed));
      if (i < 2)
        bitsCfg = {2{trsBitsCfg_type'({i == 0, 1'b1, 2'b0, 4'hf, 9'h0})}};
      cyc(60);
      for (int j = 0; j < 2; j++) begin
        b = bitsCfg[j];
        chk(8'(bitsOutActive[j]), 8'(b.facilityInService));
        chk(8'(bitsOutB8zs[j]), 8'(b.facilityInService & b.b8zs));
        if (!b.facilityInService || (b.esf && b.syncMsgEn))
          chk(8'(bitsOutAis[j]), 8'h0);
        else if (b.alarmSignalQualityLimit == 4'hf)
          chk(8'(bitsOutAis[j]), 8'h1);
        else
          chk(8'(bitsOutAis[j]), 8'(expAis(j)));
        if (b.facilityInService)
          chk(8'(outSource[j]), 8'(expOut(j)));
      end
    end
    complete_run();
  end
endmodule
